/* File: hw/sio_pkg.sv */
// What this block does
// - data-set-change bit 7 sets on modem change per terminal ready; status read clears
// - bits 6 and 5 show inverted data set ready and carrier detect inputs
// - async mode bit 4 flags framing error, cleared by good stop bit
// - sync mode bit 4 flags sync match; delayed when stripping; receiver off clears
// - delimiter stripping disables parity; bit 3 flags previous char was delimiter
// - otherwise bit 3 flags parity error when parity enabled; receiver off clears
// - bit 2 flags overrun on unread holding register; clears next transfer
// - bit 1 data ready sets on holding load, clears on read or disable
// - bit 0 holding empty sets on transfer, clears on write or disable
// - on chip select fall, bits 7-3 match identity selects device, reply low
// - read select: 000 control one, 010 control two, 100 status, 110 receive
// - read strobe low drives register; chip select and read strobe high deselect; receive read clears ready
// - write select: 000 control one, 010 control two, 100 sync pair, 110 transmit
// - write strobe low latches bus data; transmit write clears holding empty
// - writes to 100 load sync then delimiter; any write or read of another register resets pointer, status reads keep it
// - interrupts on receive, holding empty, modem changes, ring per terminal ready
// - any interrupt condition drives irq low and survives a same-cycle acknowledge
// - acknowledge passes down chain unless interrupting; winner drives reply low
// - winner puts identity on bits 7-3, bit 2 one unless holding empty cause
// - pending interrupt clears only on chip select with chain acknowledge
// - bus drivers release when read strobe returns high
// - terminal ready enables carrier and data set ready interrupts, else ring only
// - clearing receiver enable clears all receiver status flags
package sio_pkg;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ID_W   = 5;
  localparam int unsigned FIFO_D = 8;
  // register select, address bits 2-0
  localparam logic [2:0] SEL_CTL_ONE  = 3'h0;
  localparam logic [2:0] SEL_CTL_TWO  = 3'h2;
  localparam logic [2:0] SEL_STATUS   = 3'h4;
  localparam logic [2:0] SEL_RX_HOLD  = 3'h6;
  // address field positions
  localparam int unsigned ADDR_ID_LSB = 3;
  // control one bits
  localparam int unsigned C1_TERM_RDY = 0;
  localparam int unsigned C1_TX_EN    = 1;
  localparam int unsigned C1_RX_EN    = 2;
  localparam int unsigned C1_PAR_EN   = 3;
  localparam int unsigned C1_DLE_STRIP = 4;
  // control two bits
  localparam int unsigned C2_SYNC_STRIP = 3;
  localparam int unsigned C2_SYNC_MODE  = 5;
  // reset values
  localparam logic [7:0] CTL_ONE_RST = 8'h00;
  localparam logic [7:0] CTL_TWO_RST = 8'h00;
  localparam logic [7:0] BYTE_RST    = 8'h00;
  // arbitrary neutral identity default
  localparam logic [4:0] ID_DEFAULT  = 5'h01;
endpackage

/* File: hw/sio_status_bus.sv */
`timescale 1ns/1ns
// ----------------------------------------
// transmit fifo
// ----------------------------------------
module tx_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             clock,
  input  wire logic             resetn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wr_ff, rd_ff, nxt_wr, nxt_rd;
  logic [AW:0]      cnt_ff, nxt_cnt;
  logic             push, pop;

  assign in_ready  = (cnt_ff != FULL_CNT);
  assign out_valid = (cnt_ff != '0);
  assign out_data  = mem_ff[rd_ff];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_comb begin
    nxt_wr  = wr_ff;
    nxt_rd  = rd_ff;
    nxt_cnt = cnt_ff;
    if (push) begin
      nxt_wr = (wr_ff == LAST) ? '0 : wr_ff + 1'b1;
    end
    if (pop) begin
      nxt_rd = (rd_ff == LAST) ? '0 : rd_ff + 1'b1;
    end
    if (push & ~pop) begin
      nxt_cnt = cnt_ff + 1'b1;
    end else if (pop & ~push) begin
      nxt_cnt = cnt_ff - 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      wr_ff  <= '0;
      rd_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      wr_ff  <= nxt_wr;
      rd_ff  <= nxt_rd;
      cnt_ff <= nxt_cnt;
    end
  end

  // storage needs no reset; words are only read once counted in
  always_ff @(posedge clock) begin
    if (push) begin
      mem_ff[wr_ff] <= in_data;
    end
  end
endmodule

// ----------------------------------------
// status, host bus and interrupt chain
// ----------------------------------------
module sio_status_bus
  import sio_pkg::*;
#(
  parameter int unsigned FIFO_DEPTH = sio_pkg::FIFO_D
) (
  input  wire logic                       clock,
  input  wire logic                       resetn,
  input  wire logic [sio_pkg::ID_W-1:0]   id_code,
  input  wire logic [sio_pkg::DATA_W-1:0] shared_bus_lines_i,
  output logic      [sio_pkg::DATA_W-1:0] shared_bus_lines_o,
  output logic                            shared_bus_lines_oe,
  input  wire logic                       chip_select_n,
  input  wire logic                       read_strobe_n,
  input  wire logic                       write_strobe_n,
  output logic                            bus_reply_n_o,
  output logic                            bus_reply_n_oe,
  input  wire logic                       ack_chain_in_n,
  output logic                            ack_chain_out_n,
  output logic                            irq_out_n,
  input  wire logic                       data_set_ready_n,
  input  wire logic                       carrier_detect_n,
  input  wire logic                       ring_n,
  input  wire logic                       clear_to_send_n,
  output logic                            term_ready_n,
  input  wire logic                       rx_char_valid,
  input  wire logic [sio_pkg::DATA_W-1:0] rx_char_data,
  input  wire logic                       rx_frame_err,
  input  wire logic                       rx_parity_err,
  output logic                            tx_char_valid,
  input  wire logic                       tx_char_ready,
  output logic      [sio_pkg::DATA_W-1:0] tx_char_data
);
  import sio_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [7:0] ctl1_ff, ctl2_ff, sync_ff, dle_ff, rhr_ff, thr_ff, bus_ff;
  logic [7:0] nxt_ctl1, nxt_ctl2, nxt_sync, nxt_dle, nxt_rhr, nxt_thr, nxt_bus;
  logic [2:0] reg_sel_ff, nxt_reg_sel;
  logic cs_q_ff, re_q_ff, we_q_ff;
  logic sel_ff, nxt_sel, resp_ff, nxt_resp, pass_ff, nxt_pass;
  logic ptr_dle_ff, nxt_ptr_dle;
  logic dsc_ff, nxt_dsc, fe_ff, nxt_fe, pe_ff, nxt_pe, or_ff, nxt_or;
  logic dr_ff, nxt_dr, tx_hold_empty_ff, nxt_tx_hold_empty, thr_full_ff, nxt_thr_full;
  logic prev_sync_ff, nxt_prev_sync, prev_dle_ff, nxt_prev_dle;
  logic dsr_q_ff, cd_q_ff, ring_q_ff;
  logic pend_ff, nxt_pend, cause_ff, nxt_cause;

  logic cs_fall, re_fall, we_fall, access_end, ack_end;
  logic rx_en, tx_en, sync_mode, dle_strip, sync_strip;
  logic match_sync, match_dle, rx_take, rx_xfer;
  logic modem_evt, tx_hold_empty_evt, rx_evt, st_read, rhr_read;
  logic tx_push, tx_room;
  logic [7:0] status_word;

  assign cs_fall    = cs_q_ff & ~chip_select_n;
  assign re_fall    = re_q_ff & ~read_strobe_n;
  assign we_fall    = we_q_ff & ~write_strobe_n;
  assign access_end = chip_select_n & read_strobe_n;
  assign ack_end    = chip_select_n & read_strobe_n & ack_chain_in_n;

  assign rx_en      = ctl1_ff[C1_RX_EN];
  assign tx_en      = ctl1_ff[C1_TX_EN] & ~clear_to_send_n;
  assign sync_mode  = ctl2_ff[C2_SYNC_MODE];
  assign dle_strip  = sync_mode & ctl1_ff[C1_DLE_STRIP];
  assign sync_strip = sync_mode & ctl2_ff[C2_SYNC_STRIP];
  assign match_sync = (rx_char_data == sync_ff);
  assign match_dle  = (rx_char_data == dle_ff);
  assign rx_take    = rx_char_valid & rx_en;
  // stripped characters never reach the holding register
  assign rx_xfer    = rx_take & ~(dle_strip & match_dle) & ~(sync_strip & match_sync);

  assign st_read    = re_fall & sel_ff & (reg_sel_ff == SEL_STATUS);
  assign rhr_read   = re_fall & sel_ff & (reg_sel_ff == SEL_RX_HOLD);

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign status_word = {dsc_ff, ~data_set_ready_n, ~carrier_detect_n,
                        fe_ff, pe_ff, or_ff, dr_ff, tx_hold_empty_ff};
  assign shared_bus_lines_o  = bus_ff;
  assign shared_bus_lines_oe = (sel_ff | resp_ff) & ~read_strobe_n;
  assign bus_reply_n_o       = 1'b0;
  assign bus_reply_n_oe      = sel_ff | resp_ff;
  assign ack_chain_out_n     = ~pass_ff;
  assign irq_out_n           = ~pend_ff;
  assign term_ready_n        = ~ctl1_ff[C1_TERM_RDY];

  // transfer holding register into the fifo; full fifo holds it back
  assign tx_push = thr_full_ff & tx_en;

  tx_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_tx_fifo (
    .clock     (clock),
    .resetn    (resetn),
    .in_valid  (tx_push),
    .in_ready  (tx_room),
    .in_data   (thr_ff),
    .out_valid (tx_char_valid),
    .out_ready (tx_char_ready),
    .out_data  (tx_char_data)
  );

  // ----------------------------------------
  // interrupt events
  // ----------------------------------------
  always_comb begin
    modem_evt = 1'b0;
    if (ctl1_ff[C1_TERM_RDY]) begin
      modem_evt = (dsr_q_ff != data_set_ready_n) | (cd_q_ff != carrier_detect_n);
    end else begin
      modem_evt = ring_q_ff & ~ring_n;
    end
  end
  assign rx_evt   = rx_xfer;
  assign tx_hold_empty_evt = nxt_tx_hold_empty & ~tx_hold_empty_ff;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    nxt_ctl1      = ctl1_ff;
    nxt_ctl2      = ctl2_ff;
    nxt_sync      = sync_ff;
    nxt_dle       = dle_ff;
    nxt_rhr       = rhr_ff;
    nxt_thr       = thr_ff;
    nxt_reg_sel   = reg_sel_ff;
    nxt_sel       = sel_ff;
    nxt_resp      = resp_ff;
    nxt_pass      = pass_ff;
    nxt_ptr_dle   = ptr_dle_ff;
    nxt_dsc       = dsc_ff;
    nxt_fe        = fe_ff;
    nxt_pe        = pe_ff;
    nxt_or        = or_ff;
    nxt_dr        = dr_ff;
    nxt_thr_full  = thr_full_ff;
    nxt_prev_sync = prev_sync_ff;
    nxt_prev_dle  = prev_dle_ff;
    nxt_pend      = pend_ff;
    nxt_cause     = cause_ff;

    // selection and chain acknowledge
    if (cs_fall) begin
      if (!ack_chain_in_n) begin
        if (pend_ff) begin
          nxt_resp  = 1'b1;
          nxt_pend  = 1'b0;
          nxt_cause = cause_ff;
        end else begin
          nxt_pass = 1'b1;
        end
      end else if (shared_bus_lines_i[7:ADDR_ID_LSB] == id_code) begin
        nxt_sel     = 1'b1;
        // bit 0 is held low by the host, so bits 2-1 carry the choice
        nxt_reg_sel = {shared_bus_lines_i[2:1], 1'b0};
      end
    end
    if (sel_ff & access_end) begin
      nxt_sel = 1'b0;
    end
    if ((resp_ff | pass_ff) & ack_end) begin
      nxt_resp = 1'b0;
      nxt_pass = 1'b0;
    end

    // register writes
    if (we_fall & sel_ff) begin
      nxt_ptr_dle = 1'b0;
      unique case (reg_sel_ff)
        SEL_CTL_ONE: nxt_ctl1 = shared_bus_lines_i;
        SEL_CTL_TWO: nxt_ctl2 = shared_bus_lines_i;
        SEL_STATUS: begin
          if (ptr_dle_ff) begin
            nxt_dle = shared_bus_lines_i;
          end else begin
            nxt_sync    = shared_bus_lines_i;
            nxt_ptr_dle = 1'b1;
          end
        end
        default: begin
          nxt_thr      = shared_bus_lines_i;
          nxt_thr_full = 1'b1;
        end
      endcase
    end
    if (re_fall & sel_ff & (reg_sel_ff != SEL_STATUS)) begin
      nxt_ptr_dle = 1'b0;
    end

    // read side effects; a set in the same cycle wins below
    if (st_read) begin
      nxt_dsc = 1'b0;
      if (dle_strip) begin
        nxt_pe = 1'b0;
      end
    end
    if (rhr_read) begin
      nxt_dr = 1'b0;
    end
    if (modem_evt) begin
      nxt_dsc = 1'b1;
    end

    // receive path
    if (rx_take) begin
      nxt_prev_sync = match_sync;
      nxt_prev_dle  = match_dle;
      if (!sync_mode) begin
        nxt_fe = rx_frame_err;
      end else if (sync_strip) begin
        nxt_fe = prev_sync_ff;
      end else begin
        nxt_fe = match_sync;
      end
      if (dle_strip) begin
        nxt_pe = prev_dle_ff;
      end else begin
        nxt_pe = ctl1_ff[C1_PAR_EN] & rx_parity_err;
      end
    end
    if (rx_xfer) begin
      nxt_rhr = rx_char_data;
      nxt_or  = dr_ff & ~rhr_read;
      nxt_dr  = 1'b1;
    end
    if (!rx_en) begin
      nxt_fe = 1'b0;
      nxt_pe = 1'b0;
      nxt_or = 1'b0;
      nxt_dr = 1'b0;
    end

    // transmit holding; a same-cycle write refills it
    if (tx_push & tx_room & ~(we_fall & sel_ff & (reg_sel_ff == SEL_RX_HOLD))) begin
      nxt_thr_full = 1'b0;
    end

    // pending interrupt; new events win over the acknowledge clear
    if (rx_evt | modem_evt | tx_hold_empty_evt) begin
      nxt_pend = 1'b1;
    end
    if (rx_evt | modem_evt) begin
      nxt_cause = 1'b1;
    end else if (cs_fall & ~ack_chain_in_n & pend_ff) begin
      nxt_cause = 1'b0;
    end
  end

  // holding empty follows the holding register while enabled
  assign nxt_tx_hold_empty = tx_en & ~nxt_thr_full;

  // read data; identity answer during acknowledge
  always_comb begin
    nxt_bus = bus_ff;
    if (nxt_resp & ~resp_ff) begin
      // cause as it stood before the acknowledge clears it
      nxt_bus = {id_code, cause_ff, 2'b00};
    end else if (nxt_sel) begin
      unique case (nxt_reg_sel)
        SEL_CTL_ONE: nxt_bus = ctl1_ff;
        SEL_CTL_TWO: nxt_bus = ctl2_ff;
        SEL_STATUS:  nxt_bus = status_word;
        default:     nxt_bus = rhr_ff;
      endcase
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (!resetn) begin
      ctl1_ff      <= CTL_ONE_RST;
      ctl2_ff      <= CTL_TWO_RST;
      sync_ff      <= BYTE_RST;
      dle_ff       <= BYTE_RST;
      rhr_ff       <= BYTE_RST;
      thr_ff       <= BYTE_RST;
      bus_ff       <= BYTE_RST;
      reg_sel_ff   <= 3'h0;
      cs_q_ff      <= 1'b1;
      re_q_ff      <= 1'b1;
      we_q_ff      <= 1'b1;
      sel_ff       <= 1'b0;
      resp_ff      <= 1'b0;
      pass_ff      <= 1'b0;
      ptr_dle_ff   <= 1'b0;
      dsc_ff       <= 1'b0;
      fe_ff        <= 1'b0;
      pe_ff        <= 1'b0;
      or_ff        <= 1'b0;
      dr_ff        <= 1'b0;
      tx_hold_empty_ff      <= 1'b0;
      thr_full_ff  <= 1'b0;
      prev_sync_ff <= 1'b0;
      prev_dle_ff  <= 1'b0;
      dsr_q_ff     <= 1'b1;
      cd_q_ff      <= 1'b1;
      ring_q_ff    <= 1'b1;
      pend_ff      <= 1'b0;
      cause_ff     <= 1'b0;
    end else begin
      ctl1_ff      <= nxt_ctl1;
      ctl2_ff      <= nxt_ctl2;
      sync_ff      <= nxt_sync;
      dle_ff       <= nxt_dle;
      rhr_ff       <= nxt_rhr;
      thr_ff       <= nxt_thr;
      bus_ff       <= nxt_bus;
      reg_sel_ff   <= nxt_reg_sel;
      cs_q_ff      <= chip_select_n;
      re_q_ff      <= read_strobe_n;
      we_q_ff      <= write_strobe_n;
      sel_ff       <= nxt_sel;
      resp_ff      <= nxt_resp;
      pass_ff      <= nxt_pass;
      ptr_dle_ff   <= nxt_ptr_dle;
      dsc_ff       <= nxt_dsc;
      fe_ff        <= nxt_fe;
      pe_ff        <= nxt_pe;
      or_ff        <= nxt_or;
      dr_ff        <= nxt_dr;
      tx_hold_empty_ff      <= nxt_tx_hold_empty;
      thr_full_ff  <= nxt_thr_full;
      prev_sync_ff <= nxt_prev_sync;
      prev_dle_ff  <= nxt_prev_dle;
      dsr_q_ff     <= data_set_ready_n;
      cd_q_ff      <= carrier_detect_n;
      ring_q_ff    <= ring_n;
      pend_ff      <= nxt_pend;
      cause_ff     <= nxt_cause;
    end
  end
endmodule

/* File: bench/sio_status_bus_asserts.sv */
`timescale 1ns/1ns
// ----------------------------------------
// bus selection, interrupt chain and transmit hold checks
// ----------------------------------------
module sio_status_bus_checker
  import sio_pkg::*;
(
  input wire logic                       clock,
  input wire logic                       resetn,
  input wire logic [sio_pkg::ID_W-1:0]   id_code,
  input wire logic [sio_pkg::DATA_W-1:0] shared_bus_lines_i,
  input wire logic                       shared_bus_lines_oe,
  input wire logic                       chip_select_n,
  input wire logic                       read_strobe_n,
  input wire logic                       bus_reply_n_o,
  input wire logic                       bus_reply_n_oe,
  input wire logic                       ack_chain_in_n,
  input wire logic                       ack_chain_out_n,
  input wire logic                       irq_out_n,
  input wire logic                       tx_char_valid,
  input wire logic                       tx_char_ready,
  input wire logic [sio_pkg::DATA_W-1:0] tx_char_data
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  sequence cs_fall;
    $fell(chip_select_n);
  endsequence
  sequence ack_req;
    cs_fall ##0 !ack_chain_in_n;
  endsequence
  sequence all_idle;
    chip_select_n && read_strobe_n && ack_chain_in_n;
  endsequence

  chk_select_match: assert property (cs_fall ##0 ack_chain_in_n
    ##0 (shared_bus_lines_i[7:3] == id_code) |=> bus_reply_n_oe) else $error("no reply on match");
  chk_select_miss: assert property (cs_fall ##0 ack_chain_in_n
    ##0 (shared_bus_lines_i[7:3] != id_code) ##0 !bus_reply_n_oe |=> !bus_reply_n_oe[*2])
    else $error("reply on foreign identity");
  chk_reply_drop: assert property (all_idle[*2] |-> !bus_reply_n_oe)
    else $error("reply held after deselect");
  chk_reply_cause: assert property ($rose(bus_reply_n_oe) |-> !bus_reply_n_o
    && !$past(chip_select_n)) else $error("reply without chip select");
  chk_drive_read: assert property (shared_bus_lines_oe |-> !read_strobe_n
    && bus_reply_n_oe) else $error("bus driven outside read");
  chk_irq_ack: assert property (ack_req ##0 !irq_out_n |=> irq_out_n
    && bus_reply_n_oe && ack_chain_out_n) else $error("pending ack not taken");
  chk_ack_pass: assert property (ack_req ##0 irq_out_n |=> !ack_chain_out_n
    && !bus_reply_n_oe) else $error("ack not passed down");
  chk_irq_hold: assert property (!irq_out_n && !($fell(chip_select_n)
    && !ack_chain_in_n) |=> !irq_out_n) else $error("irq dropped without ack");
  chk_chain_free: assert property (!ack_chain_out_n ##0 all_idle |=> ack_chain_out_n)
    else $error("chain output held");
  chk_tx_hold: assert property (tx_char_valid && !tx_char_ready
    |=> tx_char_valid && $stable(tx_char_data)) else $error("tx char dropped");
endmodule

bind sio_status_bus sio_status_bus_checker u_chk (
  .clock(clock), .resetn(resetn), .id_code(id_code),
  .shared_bus_lines_i(shared_bus_lines_i), .shared_bus_lines_oe(shared_bus_lines_oe),
  .chip_select_n(chip_select_n), .read_strobe_n(read_strobe_n),
  .bus_reply_n_o(bus_reply_n_o), .bus_reply_n_oe(bus_reply_n_oe),
  .ack_chain_in_n(ack_chain_in_n), .ack_chain_out_n(ack_chain_out_n),
  .irq_out_n(irq_out_n), .tx_char_valid(tx_char_valid),
  .tx_char_ready(tx_char_ready), .tx_char_data(tx_char_data)
);

/* File: bench/host_model.sv */
`timescale 1ns/1ns
// ----------------------------------------
// host controller on the shared bus
// ----------------------------------------
module host_model
  import sio_pkg::*;
(
  input  wire logic                       clock,
  input  wire logic [sio_pkg::DATA_W-1:0] dev_data,
  input  wire logic                       reply_n,
  output logic      [sio_pkg::DATA_W-1:0] bus_v,
  output logic                            cs_n,
  output logic                            rd_n,
  output logic                            wr_n,
  output logic                            ack_n
);
  logic [8:0] got_v;
  event       got;
  initial begin
    bus_v = 8'h00;
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    ack_n = 1'b1;
  end
  // one access; got_v is {replied, data}
  task automatic acc(input logic [7:0] a, input logic wr, input logic [7:0] wd,
                     input logic ak);
    logic rep;
    rep = 1'b0;
    @(posedge clock);
    // cleared only now, so the compare of the last read has taken it
    got_v = 9'h000;
    #1;
    bus_v = {a[7:1], 1'b0};
    cs_n = 1'b0;
    ack_n = ~ak;
    for (int i = 0; i < 6 && !rep; i++) begin
      @(posedge clock);
      rep = ~reply_n;
    end
    #1;
    if (rep && wr) begin
      bus_v = wd;
      wr_n = 1'b0;
      repeat (2) @(posedge clock);
      #1;
      wr_n = 1'b1;
    end else if (rep) begin
      rd_n = 1'b0;
      repeat (2) @(posedge clock);
      got_v = {1'b1, dev_data};
      #1;
      rd_n = 1'b1;
    end
    repeat (2) @(posedge clock);
    #1;
    cs_n = 1'b1;
    ack_n = 1'b1;
    // released lines show the inverse, never a stale value
    bus_v = ~bus_v;
    repeat (3) @(posedge clock);
    if (!wr) -> got;
  endtask
endmodule

/* File: bench/test_serial_comm_status_bus_interrupt.sv */
`timescale 1ns/1ns
module test_serial_comm_status_bus_interrupt;
  import sio_pkg::*;
  localparam logic [4:0] DEV_ID = 5'h13; // arbitrary identity
  typedef struct {
    string      nm;
    logic [8:0] v;
  } exp_t;
  logic       clock, resetn, dsr_n, cd_n, ring_n, rx_v, rx_fe, rx_pe, tx_rdy, drain, cts_n;
  logic [7:0] rx_d, host_v, dut_o, tx_d, bus, r;
  logic       dut_oe, rep_o, rep_oe, reply_n, cs_n, rd_n, wr_n, ack_n, ack_out_n;
  logic       irq_n, term_n, tx_v;
  exp_t       expq[$];
  exp_t       e;
  logic [7:0] txq[$];
  int         num_errors, samples_checked;
  assign bus = dut_oe ? dut_o : host_v;
  assign reply_n = rep_oe ? rep_o : 1'b1;

  sio_status_bus #(.FIFO_DEPTH(FIFO_D)) dut (
    .clock(clock), .resetn(resetn), .id_code(DEV_ID), .shared_bus_lines_i(bus),
    .shared_bus_lines_o(dut_o), .shared_bus_lines_oe(dut_oe), .chip_select_n(cs_n),
    .read_strobe_n(rd_n), .write_strobe_n(wr_n), .bus_reply_n_o(rep_o),
    .bus_reply_n_oe(rep_oe), .ack_chain_in_n(ack_n), .ack_chain_out_n(ack_out_n),
    .irq_out_n(irq_n), .data_set_ready_n(dsr_n), .carrier_detect_n(cd_n),
    .ring_n(ring_n), .clear_to_send_n(cts_n), .term_ready_n(term_n),
    .rx_char_valid(rx_v), .rx_char_data(rx_d), .rx_frame_err(rx_fe),
    .rx_parity_err(rx_pe), .tx_char_valid(tx_v), .tx_char_ready(tx_rdy),
    .tx_char_data(tx_d)
  );
  host_model u_host (
    .clock(clock), .dev_data(bus), .reply_n(reply_n), .bus_v(host_v),
    .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .ack_n(ack_n)
  );

  // ----------------------------------------
  // checking and closing
  // ----------------------------------------
  task automatic chk(input string nm, input logic [8:0] x, input logic [8:0] s);
    samples_checked++;
    if (x !== s) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, x, s);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial forever begin
    @(u_host.got);
    if (expq.size() == 0) begin
      chk("spare read", 9'h000, 9'h1ff);
    end else begin
      e = expq.pop_front();
      chk(e.nm, e.v, u_host.got_v);
    end
  end
  always @(posedge clock) begin
    if (tx_v === 1'b1 && tx_rdy === 1'b1) begin
      if (txq.size() == 0) chk("tx spare", 9'h000, 9'h1ff);
      else chk("tx char", {1'b0, txq.pop_front()}, {1'b0, tx_d});
    end
  end

  // ----------------------------------------
  // stimulus helpers
  // ----------------------------------------
  task automatic rd(input logic [7:0] a, input logic ak, input logic [8:0] x, input string nm);
    expq.push_back('{nm, x});
    u_host.acc(a, 1'b0, 8'h00, ak);
  endtask
  task automatic wr(input logic [2:0] s, input logic [7:0] d);
    u_host.acc({DEV_ID, s}, 1'b1, d, 1'b0);
  endtask
  task automatic st(input logic [7:0] x);
    rd({DEV_ID, SEL_STATUS}, 1'b0, {1'b1, x}, "status");
  endtask
  task automatic ack(input logic c);
    rd({DEV_ID, 3'h0}, 1'b1, {1'b1, DEV_ID, c, 2'b00}, "ack id");
  endtask
  task automatic sig(input logic a, input logic b, input logic c, input logic v,
                     input logic [7:0] d, input logic fe, input logic pe);
    @(posedge clock);
    #1;
    {dsr_n, cd_n, ring_n, rx_v, rx_d, rx_fe, rx_pe} = {a, b, c, v, d, fe, pe};
    @(posedge clock);
    #1;
    rx_v = 1'b0;
    repeat (2) @(posedge clock);
  endtask
  always @(posedge clock) begin
    #1;
    tx_rdy = drain ? 1'($urandom()) : 1'b0;
  end
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    repeat (20000) @(posedge clock);
    num_errors++;
    finish_test();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {resetn, rx_v, rx_fe, rx_pe, tx_rdy, drain, rx_d} = 14'h0;
    {dsr_n, cd_n, ring_n} = 3'b111;
    cts_n = 1'b0;
    num_errors = 0;
    samples_checked = 0;
    void'($urandom(32'h8be1f5bf));
    repeat (12) @(posedge clock);
    #1;
    resetn = 1'b1;
    repeat (2) @(posedge clock);
    rd({DEV_ID, SEL_CTL_ONE}, 1'b0, {1'b1, CTL_ONE_RST}, "ctl one");
    rd({DEV_ID, SEL_CTL_TWO}, 1'b0, {1'b1, CTL_TWO_RST}, "ctl two");
    r = 8'($urandom()) & 8'hd7; // stay asynchronous
    wr(SEL_CTL_TWO, r);
    rd({DEV_ID, SEL_CTL_TWO}, 1'b0, {1'b1, r}, "ctl two");
    rd({~DEV_ID, SEL_STATUS}, 1'b0, 9'h000, "foreign id");
    rd({DEV_ID, 3'h0}, 1'b1, 9'h000, "idle ack");
    sig(1'b0, 1'b1, 1'b1, 1'b0, 8'h00, 1'b0, 1'b0);
    st(8'h40);
    sig(1'b0, 1'b1, 1'b0, 1'b0, 8'h00, 1'b0, 1'b0);
    st(8'hc0);
    st(8'h40);
    sig(1'b0, 1'b1, 1'b1, 1'b0, 8'h00, 1'b0, 1'b0);
    ack(1'b1);
    wr(SEL_CTL_ONE, 8'h01);
    sig(1'b0, 1'b0, 1'b1, 1'b0, 8'h00, 1'b0, 1'b0);
    st(8'he0);
    ack(1'b1);
    wr(SEL_CTL_ONE, 8'h0d);
    r = 8'($urandom());
    sig(1'b0, 1'b0, 1'b1, 1'b1, r, 1'b0, 1'b0);
    st(8'h62);
    rd({DEV_ID, SEL_RX_HOLD}, 1'b0, {1'b1, r}, "rx hold");
    st(8'h60);
    sig(1'b0, 1'b0, 1'b1, 1'b1, 8'($urandom()), 1'b1, 1'b1);
    st(8'h7a);
    r = 8'($urandom());
    sig(1'b0, 1'b0, 1'b1, 1'b1, r, 1'b0, 1'b0);
    st(8'h66);
    rd({DEV_ID, SEL_RX_HOLD}, 1'b0, {1'b1, r}, "rx hold");
    sig(1'b0, 1'b0, 1'b1, 1'b1, 8'($urandom()), 1'b1, 1'b1);
    wr(SEL_CTL_ONE, 8'h09);
    st(8'h60);
    ack(1'b1);
    sig(1'b0, 1'b0, 1'b1, 1'b1, 8'($urandom()), 1'b1, 1'b1);
    st(8'h60);
    rd({DEV_ID, 3'h0}, 1'b1, 9'h000, "idle ack");
    wr(SEL_CTL_ONE, 8'h03);
    st(8'h61);
    ack(1'b0);
    // eight fill the buffer, the ninth stays in the holding register
    for (int i = 0; i < 9; i++) begin
      r = 8'($urandom());
      txq.push_back(r);
      wr(SEL_RX_HOLD, r);
    end
    st(8'h60);
    drain = 1'b1;
    for (int i = 0; i < 400 && txq.size() > 0; i++) @(posedge clock);
    drain = 1'b0;
    chk("tx left", 9'h000, 9'(txq.size()));
    st(8'h61);
    #1 cts_n = 1'b1;
    st(8'h60);
    #1 cts_n = 1'b0;
    ack(1'b0);
    wr(SEL_CTL_ONE, 8'h01);
    st(8'h60);
    wr(SEL_STATUS, 8'h16);
    wr(SEL_STATUS, 8'h10);
    wr(SEL_CTL_TWO, 8'h20);
    wr(SEL_CTL_ONE, 8'h15);
    sig(1'b0, 1'b0, 1'b1, 1'b1, 8'h10, 1'b0, 1'b0);
    sig(1'b0, 1'b0, 1'b1, 1'b1, 8'h16, 1'b0, 1'b0);
    st(8'h7a);
    st(8'h72);
    repeat (4) @(posedge clock);
    chk("reads left", 9'h000, 9'(expq.size()));
    finish_test();
  end
endmodule
